// *** common/tsc_pkg.sv ***
// Purpose: shared constants of the timer start and lockstep control block
// Assumes: APB register word per index, byte address = index * 4
// Notes:   indices are kept as printed; the byte address is index shifted by 2
package tsc_pkg;

  localparam int unsigned NUM_CH     = 5;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned IDX_W      = 30;

  // register indices
  localparam logic [IDX_W-1:0] RUN_CTRL_IDX   = 30'h05FFFF00;
  localparam logic [IDX_W-1:0] GROUP_CTRL_IDX = 30'h05FFFF01;
  localparam logic [IDX_W-1:0] COUNT_IDX_BASE = 30'h05FFFF40;

  // field positions and fills
  localparam int unsigned      CH_FIELD_LSB   = 0;
  localparam int unsigned      RUN_FILL_LSB   = 5;
  localparam logic [2:0]       RUN_FILL       = 3'h7;
  localparam int unsigned      GROUP_FILL_LSB = 5;
  localparam logic [1:0]       GROUP_FILL     = 2'h3;
  localparam logic [0:0]       GROUP_TOP_BIT  = 1'h0;

  // reset values
  localparam logic [NUM_CH-1:0] RUN_RESET     = 5'h00;
  localparam logic [NUM_CH-1:0] GROUP_RESET   = 5'h00;
  localparam logic [CNT_W-1:0]  COUNT_RESET   = 16'h0000;

  // clear source codes
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_GRA  = 2'h1;
  localparam logic [1:0] CLR_GRB  = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;

endpackage

// *** logic/tsc_channel_counter.sv ***
// Purpose: one channel counter with load, clear and gated advance
// Assumes: load, clear and tick are single-cycle, synchronous to pclk
// Notes:   load beats clear, clear beats counting
module tsc_channel_counter #(
  parameter int unsigned W = tsc_pkg::CNT_W
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  // control
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic         clear,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  // state
  output logic      [W-1:0] count
);

  typedef struct packed {
    logic [W-1:0] count;
  } tsc_cnt_s;

  tsc_cnt_s state_reg;
  tsc_cnt_s state_next;

  always_comb
  begin
    state_next = state_reg;
    if (load)
    begin
      state_next.count = load_value;
    end
    else if (clear)
    begin
      state_next.count = '0;
    end
    else if (run && tick)
    begin
      state_next.count = state_reg.count + W'(1);
    end
    // no run: value holds
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg.count <= W'(tsc_pkg::COUNT_RESET);
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.count;

endmodule

// *** logic/tsc_timer_start_sync.sv ***
// Purpose: run control and lockstep grouping of a five-channel timer unit
// Assumes: APB slave, one wait state, counters live in tsc_channel_counter
// Notes:   count sources and compare clear events come from the timer core
//
// Notes on behaviour
// - run bits 4..0, one per channel; a set bit lets that counter advance.
// - a clear run bit holds its counter; run bits reset to zero.
// - run register bits 7..5 read one, ignore writes; low five are r/w.
// - a channel outside the group presets and clears on its own only.
// - a lockstep channel joins the group preset and group clear.
// - grouped channel on sync clear source clears with any group member.
// - group reg bits 4..0 reset zero; bits 6..5 read one; bit 7 undefined.
module tsc_timer_start_sync #(
  parameter int unsigned NCH = tsc_pkg::NUM_CH,
  parameter int unsigned W   = tsc_pkg::CNT_W
) (
  // clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // timer core side
  input  wire logic [NCH-1:0]    count_src_tick,
  input  wire logic [NCH-1:0]    compare_clear_evt,
  input  wire logic [2*NCH-1:0]  clear_source_select,
  output logic      [NCH-1:0]    count_enable,
  output logic      [NCH-1:0]    lockstep_enable,
  output logic                   sync_preset_strobe,
  output logic                   sync_clear_strobe,
  output logic      [W-1:0]      count_value [NCH]
);

  typedef struct packed {
    logic [NCH-1:0] run;
    logic [NCH-1:0] lockstep;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
    logic           preset_strobe;
    logic           clear_strobe;
  } tsc_top_s;

  tsc_top_s state_reg;
  tsc_top_s state_next;

  // address decode
  logic [tsc_pkg::IDX_W-1:0] idx;
  logic [tsc_pkg::IDX_W-1:0] cnt_off;
  logic                      hit_run;
  logic                      hit_group;
  logic                      hit_count;
  logic                      access;
  logic                      commit;
  logic                      wait_cyc;
  logic                      hit_any;
  logic [2:0]                cnt_ch;

  // registers sit on word indices; the two low address bits are ignored
  assign idx       = paddr[31:2];
  assign cnt_off   = idx - tsc_pkg::COUNT_IDX_BASE;
  assign hit_run   = (idx == tsc_pkg::RUN_CTRL_IDX);
  assign hit_group = (idx == tsc_pkg::GROUP_CTRL_IDX);
  assign hit_count = (idx >= tsc_pkg::COUNT_IDX_BASE)
                   && (cnt_off < tsc_pkg::IDX_W'(NCH));
  assign cnt_ch    = cnt_off[2:0];
  assign hit_any   = hit_run || hit_group || hit_count;
  assign access    = psel && penable;
  // first access cycle is the wait state in which the answer is prepared
  assign wait_cyc  = access && !state_reg.pready;
  // writes and reads commit on the edge where pready is seen high
  assign commit    = access && state_reg.pready;

  // per-channel group logic
  logic [NCH-1:0] own_clear;
  logic [NCH-1:0] chan_clear;
  logic [NCH-1:0] chan_load;
  logic [NCH-1:0] is_sync_src;
  logic           group_clear;
  logic           count_write;
  logic           run_write;
  logic           group_write;
  logic           group_preset;
  logic [W-1:0]   load_word;

  assign count_write  = commit && pwrite && hit_count;
  assign run_write    = commit && pwrite && hit_run;
  assign group_write  = commit && pwrite && hit_group;
  // counters take the low half of the write word; the rest is dropped
  assign load_word    = pwdata[W-1:0];
  // a write only presets the group when the target itself is grouped
  assign group_preset = count_write
                      && state_reg.lockstep[cnt_ch];

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1)
    begin : g_ch
      logic [1:0] sel;
      assign sel = clear_source_select[2*ch +: 2];
      assign is_sync_src[ch] = (sel == tsc_pkg::CLR_SYNC);
      // compare based clear of this channel alone
      assign own_clear[ch] = compare_clear_evt[ch]
                           && (sel == tsc_pkg::CLR_GRA
                               || sel == tsc_pkg::CLR_GRB);
      // grouped member with sync source follows the group
      assign chan_clear[ch] = own_clear[ch]
                            || (state_reg.lockstep[ch] && is_sync_src[ch]
                                && group_clear);
      // group preset reaches grouped channels; others load alone
      assign chan_load[ch] = (group_preset && state_reg.lockstep[ch])
                           || (count_write && (cnt_ch == 3'(ch)));

      tsc_channel_counter #(
        .W (W)
      ) u_cnt (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .run        (state_reg.run[ch]),
        .tick       (count_src_tick[ch]),
        .clear      (chan_clear[ch]),
        .load       (chan_load[ch]),
        .load_value (load_word),
        .count      (count_value[ch])
      );
    end
  endgenerate

  // only grouped channels can start a group clear
  assign group_clear = |(own_clear & state_reg.lockstep);

  // fill widths follow the package constants rather than bare counts
  localparam int unsigned RUN_FILL_W    = $bits(tsc_pkg::RUN_FILL);
  localparam int unsigned GROUP_FILL_W  = $bits(tsc_pkg::GROUP_FILL);
  localparam int unsigned GROUP_TOP_POS = tsc_pkg::GROUP_FILL_LSB
                                        + GROUP_FILL_W;

  // read mux; unmapped indices read as zero
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h00000000;
    if (hit_run)
    begin
      rd_word[tsc_pkg::RUN_FILL_LSB +: RUN_FILL_W]
        = tsc_pkg::RUN_FILL;
      rd_word[tsc_pkg::CH_FIELD_LSB +: NCH] = state_reg.run;
    end
    else if (hit_group)
    begin
      // undefined top bit reads as zero here
      rd_word[GROUP_TOP_POS] = tsc_pkg::GROUP_TOP_BIT;
      rd_word[tsc_pkg::GROUP_FILL_LSB +: GROUP_FILL_W]
        = tsc_pkg::GROUP_FILL;
      rd_word[tsc_pkg::CH_FIELD_LSB +: NCH] = state_reg.lockstep;
    end
    else if (hit_count)
    begin
      rd_word[W-1:0] = count_value[cnt_ch];
    end
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.preset_strobe = group_preset;
    state_next.clear_strobe  = group_clear;
    // one wait state: pready rises in the second access cycle
    state_next.pready  = wait_cyc;
    state_next.pslverr = wait_cyc && !hit_any;
    if (wait_cyc)
    begin
      state_next.prdata = pwrite ? 32'h00000000 : rd_word;
    end
    if (run_write)
    begin
      // upper bits are not stored, so writes to them vanish
      state_next.run = pwdata[tsc_pkg::CH_FIELD_LSB +: NCH];
    end
    if (group_write)
    begin
      state_next.lockstep = pwdata[tsc_pkg::CH_FIELD_LSB +: NCH];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg.run           <= tsc_pkg::RUN_RESET;
      state_reg.lockstep      <= tsc_pkg::GROUP_RESET;
      state_reg.pready        <= 1'b0;
      state_reg.pslverr       <= 1'b0;
      state_reg.prdata        <= 32'h00000000;
      state_reg.preset_strobe <= 1'b0;
      state_reg.clear_strobe  <= 1'b0;
    end
    // clk_en low in the wait state stretches a bus transfer; low at the edge where pready is high drops the write
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  assign prdata             = state_reg.prdata;
  assign pready             = state_reg.pready;
  assign pslverr            = state_reg.pslverr;
  assign count_enable       = state_reg.run;
  assign lockstep_enable    = state_reg.lockstep;
  // strobes are registered, so they trail the group event by one cycle
  assign sync_preset_strobe = state_reg.preset_strobe;
  assign sync_clear_strobe  = state_reg.clear_strobe;

endmodule

// *** test/tsc_props.sv ***
// Purpose: port assertions for run and lockstep control
// Assumes: one wait state, default channel count and width
// Notes: bound to the top module below
module tsc_props #(
  parameter int unsigned NCH = 5,
  parameter int unsigned W   = 16
) (
  // clock, reset and enable
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             clk_en,
  // apb
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [31:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  // timer core side
  input wire logic [NCH-1:0]   count_src_tick,
  input wire logic [NCH-1:0]   compare_clear_evt,
  input wire logic [2*NCH-1:0] clear_source_select,
  input wire logic [NCH-1:0]   count_enable,
  input wire logic [NCH-1:0]   lockstep_enable,
  input wire logic             sync_preset_strobe,
  input wire logic             sync_clear_strobe,
  input wire logic [W-1:0]     count_value [NCH]
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pready && pwrite && clk_en;
  wire rd = psel && penable && pready && !pwrite && !pslverr;
  // no bus commit at this edge, so no load can mask the effect
  wire quiet = clk_en && !psel;
  wire c1 = paddr == {tsc_pkg::COUNT_IDX_BASE + 30'h1, 2'h0};
  wire [1:0] s0 = clear_source_select[1:0];
  sequence s_gclr;
    quiet && lockstep_enable[0] && compare_clear_evt[0] && s0 == 2'h1;
  endsequence
  property p_adv;
    quiet && count_enable[0] && count_src_tick[0] && s0 == 2'h0 |=>
      count_value[0] == W'($past(count_value[0]) + 1);
  endproperty
  a_adv: assert property (p_adv) else $error("count did not advance");
  property p_hold;
    quiet && !count_enable[0] && s0 == 2'h0 |=> $stable(count_value[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped count moved");
  property p_run_rd;
    rd && paddr == {tsc_pkg::RUN_CTRL_IDX, 2'h0} |->
      prdata[7:5] == 3'h7 && prdata[4:0] == count_enable;
  endproperty
  a_run_rd: assert property (p_run_rd) else $error("run read bad");
  property p_ungrp;
    quiet && !lockstep_enable[2] && !count_enable[2] &&
      clear_source_select[5:4] == 2'h3 |=> $stable(count_value[2]);
  endproperty
  a_ungrp: assert property (p_ungrp) else $error("lone count moved");
  property p_cstrobe;
    s_gclr |-> ##[1:2] sync_clear_strobe;
  endproperty
  a_cstrobe: assert property (p_cstrobe)
    else $error("no clear strobe");
  property p_pstrobe;
    wr && c1 && lockstep_enable[1] |-> ##[1:2] sync_preset_strobe;
  endproperty
  a_pstrobe: assert property (p_pstrobe)
    else $error("no preset strobe");
  property p_gclr;
    s_gclr ##0 lockstep_enable[1] && clear_source_select[3:2] == 2'h3
      |=> count_value[1] == '0;
  endproperty
  a_gclr: assert property (p_gclr) else $error("group clear missed");
  property p_grp_rd;
    rd && paddr == {tsc_pkg::GROUP_CTRL_IDX, 2'h0} |->
      prdata[6:5] == 2'h3 && prdata[4:0] == lockstep_enable;
  endproperty
  a_grp_rd: assert property (p_grp_rd) else $error("group read bad");
  property p_load;
    wr && c1 && &lockstep_enable[1:0] |=>
      count_value[0] == $past(pwdata[W-1:0]);
  endproperty
  a_load: assert property (p_load) else $error("group load missed");
endmodule
bind tsc_timer_start_sync tsc_props #(.NCH(NCH), .W(W)) u_props (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .count_src_tick(count_src_tick), .compare_clear_evt(compare_clear_evt),
  .clear_source_select(clear_source_select),
  .count_enable(count_enable), .lockstep_enable(lockstep_enable),
  .sync_preset_strobe(sync_preset_strobe),
  .sync_clear_strobe(sync_clear_strobe), .count_value(count_value));

// *** test/tsc_timer_start_sync_bench.sv ***
// Purpose: directed bench for run and lockstep control
// Assumes: apb master waits for pready, clk_en held high except in the freeze scenario
// Notes: one task per scenario
`define CHK(n, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value %s exp %0h got %0h", n, e, g); \
    end \
  end
module tsc_timer_start_sync_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_RUN = {tsc_pkg::RUN_CTRL_IDX, 2'h0};
  localparam logic [31:0] A_GRP = {tsc_pkg::GROUP_CTRL_IDX, 2'h0};
  localparam logic [31:0] A_C0  = {tsc_pkg::COUNT_IDX_BASE, 2'h0};
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic        pready, pslverr, err, sp, sc;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [4:0]  tick, evt, cen, len;
  logic [9:0]  sel;
  logic [15:0] cv [5];
  int          bad_count, num_checks, cyc;
  tsc_timer_start_sync DUT (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_src_tick(tick), .compare_clear_evt(evt),
    .clear_source_select(sel), .count_enable(cen),
    .lockstep_enable(len), .sync_preset_strobe(sp),
    .sync_clear_strobe(sc), .count_value(cv));
  always #2.5 pclk = ~pclk;
  task print_verdict;
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      print_verdict;
    end
  end
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the bench timeout may end this wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task t_reset;
    apb(1'b0, A_RUN, 32'h0);
    `CHK("run reset", 32'h000000E0, rd)
    apb(1'b0, A_GRP, 32'h0);
    `CHK("group reset", 32'h00000060, rd)
    apb(1'b0, 32'h00000000, 32'h0);
    `CHK("unmapped error", 1'b1, err)
  endtask
  task t_run;
    // wrap from the top of the range is the awkward case
    apb(1'b1, A_C0, 32'h0000FFFE);
    apb(1'b1, A_RUN, 32'h000000FF);
    apb(1'b0, A_RUN, 32'h0);
    `CHK("run readback", 32'h000000FF, rd)
    `CHK("count enable", 5'h1F, cen)
    tick <= 5'h01;
    cyc_n(3);
    tick <= 5'h00;
    cyc_n(1);
    `CHK("count ch0", 16'h0001, cv[0])
    apb(1'b1, A_RUN, 32'h0);
    tick <= 5'h1F;
    cyc_n(2);
    tick <= 5'h00;
    cyc_n(1);
    `CHK("held ch0", 16'h0001, cv[0])
  endtask
  task t_group;
    apb(1'b1, A_GRP, 32'h000000FF);
    apb(1'b0, A_GRP, 32'h0);
    `CHK("group readback", 32'h0000007F, rd)
    apb(1'b1, A_GRP, 32'h00000003);
    apb(1'b1, A_C0 + 32'h8, 32'h00000005);
    apb(1'b1, A_C0 + 32'h4, 32'h00001234);
    `CHK("group load ch0", 16'h1234, cv[0])
    `CHK("lone ch2", 16'h0005, cv[2])
  endtask
  task t_clear;
    // ch0 clears on its own event, ch1 follows sync clear, ungrouped ch2 on sync source holds
    sel <= 10'h03D;
    evt <= 5'h01;
    cyc_n(1);
    evt <= 5'h00;
    cyc_n(2);
    `CHK("cleared ch0", 16'h0000, cv[0])
    `CHK("sync cleared ch1", 16'h0000, cv[1])
    `CHK("ungrouped ch2", 16'h0005, cv[2])
  endtask
  task t_freeze;
    // clk_en low must hold a running counter even with ticks present
    apb(1'b1, A_RUN, 32'h00000001);
    clk_en <= 1'b0;
    tick <= 5'h01;
    cyc_n(3);
    tick <= 5'h00;
    clk_en <= 1'b1;
    cyc_n(1);
    `CHK("frozen ch0", 16'h0000, cv[0])
    `CHK("frozen run", 5'h01, cen)
    tick <= 5'h01;
    cyc_n(1);
    tick <= 5'h00;
    cyc_n(1);
    `CHK("resumed ch0", 16'h0001, cv[0])
  endtask
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    {tick, evt, sel} = 20'h0;
    cyc_n(16);
    presetn <= 1'b1;
    cyc_n(1);
    t_reset;
    t_run;
    t_group;
    t_clear;
    t_freeze;
    print_verdict;
  end
endmodule
